// *** arms_cfg.svh ***
// constants for the acl rule mode select block
// ===========================================================================
`ifndef ARMS_CFG_SVH
`define ARMS_CFG_SVH
`define ARMS_TBL_ACL      3'h2
`define ARMS_OFS_FIRST    8'h00
`define ARMS_OFS_CLASS    8'h01
`define ARMS_OFS_ACT      8'h0b
`define ARMS_OFS_LAST     8'h0d
`define ARMS_BYTE_TOP     4'hf
`define ARMS_FRN_LSB      0
`define ARMS_FRN_W        4
`define ARMS_CLS_LSB      4
`define ARMS_SEL_LSB      2
`define ARMS_CNT_W        11
`define ARMS_UNIT_BIT     4
`define ARMS_ALG_BIT      3
`define ARMS_CLK_MHZ      50
`define ARMS_US_NS        1000
`define ARMS_CLK_NS       20
`define ARMS_US_CYC       (`ARMS_US_NS / `ARMS_CLK_NS)
`define ARMS_MS_PER_US    1000
`endif

// *** arms_pkg.sv ***
// types for the acl rule mode select block
package arms_pkg;
  typedef enum logic [1:0] {
    ARMS_CLS_OFF,
    ARMS_CLS_L2,
    ARMS_CLS_L3,
    ARMS_CLS_L4
  } arms_class_e;

  typedef struct packed {
    logic       l2_type;
    logic       l2_addr;
    logic       l3_ipmask;
    logic       l3_sada;
    logic       l4_proto;
    logic       l4_port;
    logic       l4_seq;
    logic       l2_timer;
  } arms_match_s;

  typedef struct packed {
    logic [10:0] count;
    logic        unit_ms;
    logic        alg_inc;
  } arms_timer_cfg_s;
endpackage : arms_pkg

// *** arms_decode.sv ***
// decode of rule class and match select into match enables
`timescale 1ns/1ns
`include "arms_cfg.svh"
module arms_decode
  import arms_pkg::*;
(
  input  wire logic [7:0]  class_byte,
  output arms_match_s      match_en
);
  arms_class_e cls;
  logic [1:0]  sel;

  always_comb begin
    cls      = arms_class_e'(class_byte[`ARMS_CLS_LSB +: 2]);
    sel      = class_byte[`ARMS_SEL_LSB +: 2];
    match_en = '0;
    unique case (cls)
      ARMS_CLS_OFF: match_en = '0;
      ARMS_CLS_L2: begin
        match_en.l2_timer = (sel == 2'h0);
        match_en.l2_type  = sel[0] | (sel == 2'h0);
        match_en.l2_addr  = sel[1] | (sel == 2'h0);
      end
      ARMS_CLS_L3: begin
        match_en.l3_ipmask = (sel == 2'h1);
        match_en.l3_sada   = (sel == 2'h2);
      end
      ARMS_CLS_L4: begin
        match_en.l4_proto = (sel == 2'h0);
        match_en.l4_port  = (sel == 2'h1) | (sel == 2'h2);
        match_en.l4_seq   = (sel == 2'h3);
      end
    endcase
  end
endmodule : arms_decode

// *** arms_timer.sv ***
// layer 2 packet count and timeout timer
`timescale 1ns/1ns
`include "arms_cfg.svh"
module arms_timer
  import arms_pkg::*;
#(
  parameter int US_CYCLES = `ARMS_US_CYC,
  parameter int MS_US     = `ARMS_MS_PER_US
)(
  input  wire logic            mclk,
  input  wire logic            rst_b,
  input  wire logic            enable,
  input  wire arms_timer_cfg_s cfg,
  input  wire logic            pkt_hit,
  output logic                 expire_ff
);
  logic [15:0] us_cnt_ff;
  logic [9:0]  ms_cnt_ff;
  logic [10:0] cnt_ff;
  logic        tick;
  logic        en_d_ff;

  // microsecond prescaler, then millisecond stage
  always_ff @(posedge mclk) begin
    if (!rst_b || !enable) begin
      us_cnt_ff <= '0;
      ms_cnt_ff <= '0;
    end else if (us_cnt_ff == 16'(US_CYCLES - 1)) begin
      us_cnt_ff <= '0;
      ms_cnt_ff <= (ms_cnt_ff == 10'(MS_US - 1)) ? '0 : ms_cnt_ff + 10'h1;
    end else begin
      us_cnt_ff <= us_cnt_ff + 16'h1;
    end
  end

  always_comb begin
    tick = (us_cnt_ff == 16'(US_CYCLES - 1)) &&
           (!cfg.unit_ms || (ms_cnt_ff == 10'(MS_US - 1)));
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cnt_ff    <= '0;
      expire_ff <= 1'b0;
      en_d_ff   <= 1'b0;
    end else begin
      en_d_ff   <= enable;
      expire_ff <= 1'b0;
      if (!enable) begin
        cnt_ff <= '0;
      end else if (!cfg.alg_inc) begin
        if (!en_d_ff || pkt_hit) begin
          cnt_ff <= cfg.count;
        end else if (tick && cnt_ff != '0) begin
          cnt_ff    <= cnt_ff - 11'h1;
          expire_ff <= (cnt_ff == 11'h1);
        end
      end else if (pkt_hit) begin
        if (cnt_ff + 11'h1 >= cfg.count) begin
          cnt_ff    <= '0;
          expire_ff <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff + 11'h1;
        end
      end
    end
  end

  sequence seq_inc_hit;
    enable && cfg.alg_inc && pkt_hit;
  endsequence

  sequence seq_inc_cleared;
    expire_ff && cnt_ff == '0;
  endsequence

  AST_INC_TERM: assert property (@(posedge mclk) disable iff (!rst_b)
    seq_inc_hit ##0 (cnt_ff + 11'h1 >= cfg.count) |=> seq_inc_cleared)
    else $error("terminal count did not raise expiry");
  AST_DOWN_LOAD: assert property (@(posedge mclk) disable iff (!rst_b)
    enable && en_d_ff && !cfg.alg_inc && pkt_hit |=> cnt_ff == $past(cfg.count))
    else $error("match did not reload countdown");
endmodule : arms_timer

// *** arms_top.sv ***
// acl rule entry storage, indirect byte access and mode selection
`timescale 1ns/1ns
`include "arms_cfg.svh"
module arms_top
  import arms_pkg::*;
#(
  parameter int PORTS   = 4,
  parameter int ENTRIES = 16
)(
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  ctrl0_wdata,
  input  wire logic        ctrl0_we,
  input  wire logic [7:0]  ctrl1_wdata,
  input  wire logic        ctrl1_we,
  input  wire logic [7:0]  data_wdata,
  input  wire logic        data_we,
  input  wire logic [3:0]  entry_sel,
  input  wire logic [1:0]  pkt_port,
  input  wire logic        pkt_hit,
  output logic [7:0]       data_rdata_ff,
  output logic [3:0]       action_entry_ff,
  output logic [1:0]       rule_class_ff,
  output arms_match_s      match_en_ff,
  output logic [PORTS-1:0] timer_irq_ff
);
  // ==========================================================================
  // indirect control
  logic [7:0] ctrl0_ff;
  logic [7:0] ctrl1_ff;
  logic       acl_sel;
  logic [3:0] port_idx;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ctrl0_ff <= 8'h00;
      ctrl1_ff <= 8'h00;
    end else begin
      if (ctrl0_we) ctrl0_ff <= ctrl0_wdata;
      if (ctrl1_we) ctrl1_ff <= ctrl1_wdata;
    end
  end

  always_comb begin
    acl_sel  = (ctrl0_ff[7:5] == `ARMS_TBL_ACL) && (ctrl0_ff[3:0] < 4'(PORTS));
    port_idx = ctrl0_ff[3:0];
  end

  // ==========================================================================
  // entry storage: per port, per entry, bytes 0x00 and 0x01 plus action count and routing bytes
  logic [3:0] frn_ff [PORTS][ENTRIES];
  logic [5:0] cls_ff [PORTS][ENTRIES];
  logic [7:0] act_ff [PORTS][ENTRIES][3];

  function automatic logic [3:0] byte_pos(input logic [7:0] ofs);
    byte_pos = `ARMS_BYTE_TOP - ofs[3:0];
  endfunction : byte_pos

  // action bytes kept: word bytes 4..2 (offsets 0x0b..0x0d) hold count and routing
  // index 0 is the routing byte at the last offset, index 2 the count high bits
  logic [7:0] ofs;
  logic       ofs_act;
  logic [1:0] act_idx;
  always_comb begin
    ofs     = ctrl1_ff;
    ofs_act = (ofs >= `ARMS_OFS_ACT) && (ofs <= `ARMS_OFS_LAST);
    act_idx = 2'(byte_pos(ofs) - byte_pos(`ARMS_OFS_LAST));
  end

  genvar gp, ge;
  generate
    for (gp = 0; gp < PORTS; gp++) begin : g_port
      for (ge = 0; ge < ENTRIES; ge++) begin : g_ent
        always_ff @(posedge mclk) begin
          if (!rst_b) begin
            frn_ff[gp][ge]    <= '0;
            cls_ff[gp][ge]    <= '0;
            act_ff[gp][ge][0] <= '0;
            act_ff[gp][ge][1] <= '0;
            act_ff[gp][ge][2] <= '0;
          end else if (data_we && acl_sel && port_idx == 4'(gp) && entry_sel == 4'(ge)) begin
            if (ofs == `ARMS_OFS_FIRST)
              frn_ff[gp][ge] <= data_wdata[`ARMS_FRN_LSB +: `ARMS_FRN_W];
            if (ofs == `ARMS_OFS_CLASS)
              cls_ff[gp][ge] <= data_wdata[5:0];
            if (ofs_act)
              act_ff[gp][ge][act_idx] <= data_wdata;
          end
        end
      end
    end
  endgenerate

  // ==========================================================================
  // read back, reserved bits zero
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      data_rdata_ff <= 8'h00;
    end else if (!acl_sel) begin
      data_rdata_ff <= 8'h00;
    end else if (ofs == `ARMS_OFS_FIRST) begin
      data_rdata_ff <= {4'h0, frn_ff[port_idx[1:0]][entry_sel]};
    end else if (ofs == `ARMS_OFS_CLASS) begin
      data_rdata_ff <= {2'h0, cls_ff[port_idx[1:0]][entry_sel]};
    end else if (ofs_act) begin
      data_rdata_ff <= act_ff[port_idx[1:0]][entry_sel][act_idx];
    end else begin
      data_rdata_ff <= 8'h00;
    end
  end

  // ==========================================================================
  // selected entry decode
  logic [3:0]  sel_frn;
  logic [7:0]  sel_cls;
  arms_match_s dec_match;
  always_comb begin
    sel_frn = frn_ff[pkt_port][entry_sel];
    sel_cls = {2'h0, cls_ff[pkt_port][entry_sel]};
  end

  arms_decode u_decode (
    .class_byte (sel_cls),
    .match_en   (dec_match)
  );

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      action_entry_ff <= '0;
      rule_class_ff   <= '0;
      match_en_ff     <= '0;
    end else begin
      action_entry_ff <= sel_frn;
      rule_class_ff   <= sel_cls[`ARMS_CLS_LSB +: 2];
      match_en_ff     <= dec_match;
    end
  end

  // ==========================================================================
  // per port timer configured by the entry that the first rule index names, enabled by the class of the entry at entry_sel
  generate
    for (gp = 0; gp < PORTS; gp++) begin : g_tmr
      arms_timer_cfg_s tcfg;
      logic            ten;
      logic [3:0]      aent;
      always_comb begin
        aent = frn_ff[gp][entry_sel];
        tcfg.count   = {act_ff[gp][aent][2][2:0], act_ff[gp][aent][1]};
        tcfg.unit_ms = act_ff[gp][aent][0][`ARMS_UNIT_BIT];
        tcfg.alg_inc = act_ff[gp][aent][0][`ARMS_ALG_BIT];
        ten = (cls_ff[gp][entry_sel][`ARMS_CLS_LSB +: 2] == ARMS_CLS_L2) &&
              (cls_ff[gp][entry_sel][`ARMS_SEL_LSB +: 2] == 2'h0);
      end
      arms_timer u_timer (
        .mclk      (mclk),
        .rst_b     (rst_b),
        .enable    (ten),
        .cfg       (tcfg),
        .pkt_hit   (pkt_hit && pkt_port == 2'(gp)),
        .expire_ff (timer_irq_ff[gp])
      );
    end
  endgenerate

  AST_OFF_NO_MATCH: assert property (@(posedge mclk) disable iff (!rst_b)
    rule_class_ff == 2'h0 |-> match_en_ff == '0)
    else $error("disabled class still enables matching");
  AST_FRN_PASS: assert property (@(posedge mclk) disable iff (!rst_b)
    ##1 action_entry_ff == $past(sel_frn))
    else $error("action entry not the first rule index");
  AST_RD_RSVD: assert property (@(posedge mclk) disable iff (!rst_b)
    acl_sel && ofs == `ARMS_OFS_FIRST |=> data_rdata_ff[7:4] == 4'h0)
    else $error("reserved bits read nonzero");
  AST_NOSEL: assert property (@(posedge mclk) disable iff (!rst_b)
    !acl_sel |=> data_rdata_ff == 8'h00)
    else $error("data without acl table selected");
  AST_L3_RSV: assert property (@(posedge mclk) disable iff (!rst_b)
    sel_cls[5:4] == 2'h2 && (sel_cls[3:2] == 2'h0 || sel_cls[3:2] == 2'h3) |=> match_en_ff == '0)
    else $error("reserved l3 select enabled");
  AST_L4_SEQ: assert property (@(posedge mclk) disable iff (!rst_b)
    sel_cls[5:2] == 4'b1111 |=> match_en_ff.l4_seq && !match_en_ff.l4_port)
    else $error("l4 sequence select wrong");
endmodule : arms_top

// *** arms_top_tb.sv ***
// self-checking bench for the acl rule mode select block
`timescale 1ns/1ns
module arms_top_tb
  import arms_pkg::*;
;
  // ==========
  // signals
  logic        mclk        = 1'b0;
  logic        rst_b       = 1'b0;
  logic [7:0]  ctrl0_wdata = 8'h00;
  logic        ctrl0_we    = 1'b0;
  logic [7:0]  ctrl1_wdata = 8'h00;
  logic        ctrl1_we    = 1'b0;
  logic [7:0]  data_wdata  = 8'h00;
  logic        data_we     = 1'b0;
  logic [3:0]  entry_sel   = 4'h2;
  logic [1:0]  pkt_port    = 2'h1;
  logic        pkt_hit     = 1'b0;
  logic [7:0]  data_rdata_ff;
  logic [3:0]  action_entry_ff;
  logic [1:0]  rule_class_ff;
  arms_match_s match_en_ff;
  logic [3:0]  timer_irq_ff;
  int          miscompares = 0;
  int          comparisons = 0;
  logic [7:0]  v;

  arms_top dut (
    .mclk            (mclk),
    .rst_b           (rst_b),
    .ctrl0_wdata     (ctrl0_wdata),
    .ctrl0_we        (ctrl0_we),
    .ctrl1_wdata     (ctrl1_wdata),
    .ctrl1_we        (ctrl1_we),
    .data_wdata      (data_wdata),
    .data_we         (data_we),
    .entry_sel       (entry_sel),
    .pkt_port        (pkt_port),
    .pkt_hit         (pkt_hit),
    .data_rdata_ff   (data_rdata_ff),
    .action_entry_ff (action_entry_ff),
    .rule_class_ff   (rule_class_ff),
    .match_en_ff     (match_en_ff),
    .timer_irq_ff    (timer_irq_ff)
  );

  always #10 mclk = ~mclk;

  // ==========
  // helpers
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask : tick

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk8

  task automatic sel(input logic [7:0] c0, input logic [7:0] ofs);
    ctrl0_wdata = c0;
    ctrl0_we = 1'b1;
    tick(1);
    ctrl0_we = 1'b0;
    ctrl1_wdata = ofs;
    ctrl1_we = 1'b1;
    tick(1);
    ctrl1_we = 1'b0;
  endtask : sel

  task automatic wr(input logic [7:0] c0, input logic [7:0] ofs, input logic [7:0] val);
    sel(c0, ofs);
    data_wdata = val;
    data_we = 1'b1;
    tick(1);
    data_we = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] c0, input logic [7:0] ofs, output logic [7:0] val);
    sel(c0, ofs);
    tick(3);
    val = data_rdata_ff;
  endtask : rd

  task automatic hit;
    pkt_hit = 1'b1;
    tick(1);
    pkt_hit = 1'b0;
  endtask : hit

  // waits up to hi cycles; a pulse must land in lo..hi when one is expected
  task automatic watch(input int lo, input int hi, input logic exp);
    int n;
    n = 0;
    while (n < hi && timer_irq_ff === 4'h0) begin
      tick(1);
      n++;
    end
    chk8("irq fired", {7'h00, exp}, {7'h00, timer_irq_ff !== 4'h0});
    if (exp) begin
      chk8("irq port", 8'h02, {4'h0, timer_irq_ff});
      chk8("irq window", 8'h01, {7'h00, (n >= lo) && (n <= hi)});
      tick(1);
      chk8("irq pulse", 8'h00, {4'h0, timer_irq_ff});
    end
  endtask : watch

  function automatic logic [7:0] exp_match(input logic [1:0] c, input logic [1:0] s);
    case (c)
      2'h1: return (s == 2'h0) ? 8'hc1 : {s[0], s[1], 6'h00};
      2'h2: return (s == 2'h1) ? 8'h20 : (s == 2'h2) ? 8'h10 : 8'h00;
      2'h3: return (s == 2'h0) ? 8'h08 : (s == 2'h3) ? 8'h02 : 8'h04;
      default: return 8'h00;
    endcase
  endfunction : exp_match

  // ==========
  // scenarios
  task automatic t_reset;
    chk8("reset outputs", 8'h00, {action_entry_ff, rule_class_ff, 2'h0});
    chk8("reset match", 8'h00, match_en_ff);
    rd(8'h41, 8'h01, v);
    chk8("class reset", 8'h00, v);
    $display("test reset done");
  endtask : t_reset

  task automatic t_first;
    wr(8'h41, 8'h00, 8'hf5);
    rd(8'h41, 8'h00, v);
    chk8("first index", 8'h05, v);
    entry_sel = 4'h3;
    wr(8'h41, 8'h00, 8'h0a);
    rd(8'h41, 8'h00, v);
    chk8("other entry", 8'h0a, v);
    entry_sel = 4'h2;
    rd(8'h41, 8'h00, v);
    chk8("entry kept", 8'h05, v);
    chk8("action entry", 8'h05, {4'h0, action_entry_ff});
    $display("test first index done");
  endtask : t_first

  task automatic t_class;
    logic [1:0] c;
    logic [1:0] s;
    for (int i = 0; i < 16; i++) begin
      c = i[3:2];
      s = i[1:0];
      wr(8'h41, 8'h01, {2'b11, c, s, 2'b00});
      rd(8'h41, 8'h01, v);
      chk8("class byte", {2'b00, c, s, 2'b00}, v);
      chk8("rule class", {6'h00, c}, {6'h00, rule_class_ff});
      chk8("match enables", exp_match(c, s), match_en_ff);
    end
    $display("test class decode done");
  endtask : t_class

  task automatic t_refuse;
    wr(8'h21, 8'h00, 8'h0a);
    wr(8'h45, 8'h00, 8'h0a);
    wr(8'h41, 8'h05, 8'h77);
    rd(8'h41, 8'h00, v);
    chk8("refused write", 8'h05, v);
    rd(8'h41, 8'h05, v);
    chk8("unused offset", 8'h00, v);
    rd(8'h21, 8'h00, v);
    chk8("wrong table read", 8'h00, v);
    $display("test refusal done");
  endtask : t_refuse

  task automatic t_dec;
    wr(8'h41, 8'h01, 8'h00);
    wr(8'h41, 8'h0b, 8'h00);
    wr(8'h41, 8'h0c, 8'h03);
    wr(8'h41, 8'h00, 8'h02);
    wr(8'h41, 8'h0d, 8'h10);
    rd(8'h41, 8'h0c, v);
    chk8("count low byte", 8'h03, v);
    rd(8'h41, 8'h0d, v);
    chk8("routing byte", 8'h10, v);
    wr(8'h41, 8'h01, 8'h10);
    watch(0, 400, 1'b0);
    wr(8'h41, 8'h01, 8'h00);
    wr(8'h41, 8'h0d, 8'h00);
    wr(8'h41, 8'h01, 8'h10);
    tick(80);
    hit();
    watch(95, 200, 1'b1);
    $display("test countdown done");
  endtask : t_dec

  task automatic t_inc;
    wr(8'h41, 8'h01, 8'h00);
    wr(8'h41, 8'h0d, 8'h08);
    repeat (3) hit();
    watch(0, 20, 1'b0);
    wr(8'h41, 8'h01, 8'h10);
    tick(5);
    // second round shows the counter restarted after the pulse
    for (int r = 0; r < 2; r++) begin
      for (int k = 0; k < 3; k++) begin
        hit();
        watch(0, (k == 2) ? 4 : 20, k == 2);
      end
    end
    $display("test packet count done");
  endtask : t_inc

  // ==========
  // run control
  task automatic test_done;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    test_done();
  end

  initial begin
    repeat (2) @(negedge mclk);
    rst_b = 1'b1;
    t_reset();
    t_first();
    t_class();
    t_refuse();
    t_dec();
    t_inc();
    test_done();
  end
endmodule : arms_top_tb
